// ==== rtl/sync_ethernet_esmc_ql_control.sv ====
// Per-link synchronous Ethernet control at the user_network_port, provider side:
// synchronous transmit mode, ESMC frame generation and reception, and QL handling.
// Assumes a byte-wide MAC stream on link_clk and management strobes on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module sync_ethernet_esmc_ql_control #(
  parameter int unsigned ONE_SEC = esmc_pkg::ONE_SEC_CYCLES,
  // Arbitrary neutral values: source address and organisation field.
  parameter logic [47:0] SRC_ADDR = 48'h020000000001,
  parameter logic [23:0] ORG_ID = 24'h000000
) (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link clock of the MAC stream.
  input wire logic link_clk,
  // Management configuration, clk_sys domain.
  input wire logic cfg_sync_mode,
  input wire logic pair_lock,
  input wire logic pair_sync_mode,
  input wire logic cmd_esmc_enable,
  input wire logic cmd_esmc_disable,
  input wire logic cmd_ql_enable,
  input wire logic cmd_ql_disable,
  input wire logic ql_fault,
  input wire logic [3:0] local_ql,
  // Other slow-protocol users, clk_sys domain.
  input wire logic other_slow_req,
  output logic other_slow_grant,
  // Status, clk_sys domain.
  output logic tx_clk_from_eec,
  output logic clock_source_selectable,
  output logic esmc_active,
  output logic ql_active,
  output logic [3:0] peer_ql,
  output logic peer_ql_update,
  output logic esmc_rx_dropped,
  // Transmit stream, link_clk domain.
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Receive stream, link_clk domain.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [1:0] {TX_IDLE, TX_SEND} tx_state_t;

  logic sync_req;
  logic sync_prev;
  logic esmc_on;
  logic ql_on;
  logic ql_eff;
  logic [31:0] sec_cnt;
  logic [31:0] win_cnt;
  logic esmc_tick;
  logic win_tick;
  logic [3:0] slow_cnt;
  logic slow_room;
  logic esmc_pend;
  logic esmc_grant;
  logic [3:0] tx_ql_hold;
  logic tx_req_tgl;
  logic rx_tgl_s;
  logic rx_tgl_seen;
  logic rx_event;
  logic tx_req_s;
  logic tx_req_seen;
  tx_state_t tx_state;
  logic [5:0] tx_idx;
  logic [3:0] link_ql;
  logic [7:0] rom_data;
  logic rom_last;
  logic [5:0] rx_idx;
  logic rx_match;
  logic [3:0] rx_ql_cap;
  logic [3:0] rx_ql_word;
  logic rx_tgl;
  logic [7:0] rx_expect;
  logic rx_checked;
  logic [5:0] rk;

  // ==========================================================================
  // Configuration, clk_sys domain
  // ==========================================================================
  // A locked pair takes the shared group setting, so both links agree.
  assign sync_req = pair_lock ? pair_sync_mode : cfg_sync_mode;

  // Previous sync level, to find the enable edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev <= esmc_pkg::SYNC_RST;
    end else begin
      sync_prev <= sync_req;
    end
  end

  // ESMC follows sync mode on, then management may switch it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      esmc_on <= esmc_pkg::ESMC_RST;
    end else if (!sync_req) begin
      esmc_on <= 1'b0;
    end else if (!sync_prev) begin
      esmc_on <= 1'b1;
    end else if (cmd_esmc_disable) begin
      esmc_on <= 1'b0;
    end else if (cmd_esmc_enable) begin
      esmc_on <= 1'b1;
    end
  end

  // QL handling comes up with ESMC and is otherwise under management.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ql_on <= esmc_pkg::QL_RST;
    end else if (!sync_req || !esmc_on) begin
      ql_on <= 1'b1;
    end else if (cmd_ql_disable) begin
      ql_on <= 1'b0;
    end else if (cmd_ql_enable) begin
      ql_on <= 1'b1;
    end
  end

  // An operational fault disables QL without touching the admin setting.
  assign ql_eff = ql_on && esmc_on && !ql_fault;

  // Status flags; the aggregation member state is deliberately not an input.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_clk_from_eec <= 1'b0;
      clock_source_selectable <= 1'b1;
      esmc_active <= 1'b0;
      ql_active <= 1'b0;
    end else begin
      tx_clk_from_eec <= sync_prev;
      clock_source_selectable <= !(sync_prev && esmc_on);
      esmc_active <= esmc_on;
      ql_active <= ql_eff;
    end
  end

  // ==========================================================================
  // One-second pacing and slow-protocol budget, clk_sys domain
  // ==========================================================================
  // The ESMC tick counter idles at zero while ESMC is off.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt <= 32'h0;
    end else if (!esmc_on) begin
      sec_cnt <= 32'h0;
    end else if (sec_cnt == ONE_SEC - 1) begin
      sec_cnt <= 32'h0;
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end

  assign esmc_tick = esmc_on && (sec_cnt == ONE_SEC - 1);

  // The budget window runs always, since other slow protocols keep sending.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= 32'h0;
    end else if (win_tick) begin
      win_cnt <= 32'h0;
    end else begin
      win_cnt <= win_cnt + 32'h1;
    end
  end

  assign win_tick = (win_cnt == ONE_SEC - 1);
  assign slow_room = (32'(slow_cnt) < esmc_pkg::SLOW_MAX_PER_SEC);
  assign esmc_grant = esmc_pend && slow_room && esmc_on;

  // Count every granted slow-protocol frame within the window.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt <= 4'h0;
    end else if (win_tick) begin
      slow_cnt <= 4'h0;
    end else if (esmc_grant || (other_slow_req && slow_room)) begin
      slow_cnt <= slow_cnt + 4'h1;
    end
  end

  // ESMC wins the budget; other protocols take what is left.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      other_slow_grant <= 1'b0;
    end else begin
      other_slow_grant <= other_slow_req && slow_room && !esmc_grant;
    end
  end

  // A pending ESMC send survives a full budget until the window reopens.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      esmc_pend <= 1'b0;
    end else if (!esmc_on) begin
      esmc_pend <= 1'b0;
    end else if (esmc_tick) begin
      esmc_pend <= 1'b1;
    end else if (esmc_grant) begin
      esmc_pend <= 1'b0;
    end
  end

  // The quality code is frozen per frame so the link side reads a stable word.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_ql_hold <= esmc_pkg::QL_DNU;
      tx_req_tgl <= 1'b0;
    end else if (esmc_grant) begin
      tx_ql_hold <= ql_eff ? local_ql : esmc_pkg::QL_DNU;
      tx_req_tgl <= !tx_req_tgl;
    end
  end

  // ==========================================================================
  // Receive results, clk_sys domain
  // ==========================================================================
  level_sync #(.W(1)) u_rx_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(rx_tgl),
    .q(rx_tgl_s)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_tgl_seen <= 1'b0;
    end else begin
      rx_tgl_seen <= rx_tgl_s;
    end
  end

  assign rx_event = rx_tgl_s ^ rx_tgl_seen;

  // The captured word changes with the toggle and is stable for a whole frame time after it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      peer_ql <= esmc_pkg::PEER_QL_RST;
      peer_ql_update <= 1'b0;
      esmc_rx_dropped <= 1'b0;
    end else begin
      peer_ql_update <= rx_event && esmc_on && ql_eff;
      esmc_rx_dropped <= rx_event && !esmc_on;
      if (rx_event && esmc_on && ql_eff) begin
        peer_ql <= rx_ql_word;
      end
    end
  end

  // ==========================================================================
  // Transmit framer, link_clk domain
  // ==========================================================================
  level_sync #(.W(1)) u_tx_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .d(tx_req_tgl),
    .q(tx_req_s)
  );

  esmc_frame_rom #(
    .SRC_ADDR(SRC_ADDR),
    .ORG_ID(ORG_ID)
  ) u_rom (
    .idx(tx_idx),
    .ql(link_ql),
    .data(rom_data),
    .last(rom_last)
  );

  // One frame per request; requests are a second apart so none overlap.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_req_seen <= 1'b0;
      tx_idx <= 6'd0;
      link_ql <= esmc_pkg::QL_DNU;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_req_s != tx_req_seen) begin
            tx_req_seen <= tx_req_s;
            link_ql <= tx_ql_hold;
            tx_idx <= 6'd0;
            tx_state <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (!tx_valid || tx_ready) begin
            if (tx_valid && tx_last) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              tx_state <= TX_IDLE;
            end else begin
              tx_valid <= 1'b1;
              tx_data <= rom_data;
              tx_last <= rom_last;
              tx_idx <= tx_idx + 6'd1;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Receive parser, link_clk domain
  // ==========================================================================
  // Expected header byte at the current receive position.
  always_comb begin
    rk = 6'd0;
    rx_expect = 8'h00;
    rx_checked = 1'b1;
    if (rx_idx < esmc_pkg::POS_SA) begin
      rk = esmc_pkg::POS_SA - 6'd1 - rx_idx;
      rx_expect = esmc_pkg::SLOW_PROTO_DA[{rk[2:0], 3'b000} +: 8];
    end else if (rx_idx == esmc_pkg::POS_ETYPE) begin
      rx_expect = esmc_pkg::SLOW_PROTO_ETYPE[15:8];
    end else if (rx_idx == esmc_pkg::POS_ETYPE + 6'd1) begin
      rx_expect = esmc_pkg::SLOW_PROTO_ETYPE[7:0];
    end else if (rx_idx == esmc_pkg::POS_SUBTYPE) begin
      rx_expect = esmc_pkg::ESMC_SUBTYPE;
    end else begin
      rx_checked = 1'b0;
    end
  end

  // Frames too short to hold the QL byte are not reported.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_idx <= 6'd0;
      rx_match <= 1'b1;
      rx_ql_cap <= esmc_pkg::QL_DNU;
      rx_ql_word <= esmc_pkg::QL_DNU;
      rx_tgl <= 1'b0;
    end else if (rx_valid) begin
      if (rx_last) begin
        rx_idx <= 6'd0;
        rx_match <= 1'b1;
        if (rx_match && rx_idx > esmc_pkg::POS_QL) begin
          rx_ql_word <= rx_ql_cap;
          rx_tgl <= !rx_tgl;
        end
      end else begin
        if (rx_idx != 6'h3f) begin
          rx_idx <= rx_idx + 6'd1;
        end
        if (rx_checked && rx_data != rx_expect) begin
          rx_match <= 1'b0;
        end
        if (rx_idx == esmc_pkg::POS_QL) begin
          rx_ql_cap <= rx_data[3:0];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/esmc_pkg.sv ====
// Constants shared by the synchronous Ethernet port controller and its helpers.
// Assumes a 100 MHz system clock and a 60-byte ESMC frame without FCS.
package esmc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ESMC_PERIOD_NS = 1000000000;
  localparam int unsigned ONE_SEC_CYCLES = ESMC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOW_MAX_PER_SEC = 10;

  // ==========================================================================
  // Reset values of the per-link controls
  // ==========================================================================
  localparam logic SYNC_RST = 1'b0;
  localparam logic ESMC_RST = 1'b0;
  localparam logic QL_RST = 1'b0;
  localparam logic [3:0] PEER_QL_RST = 4'hf;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam logic [47:0] SLOW_PROTO_DA = 48'h0180c2000002;
  localparam logic [15:0] SLOW_PROTO_ETYPE = 16'h8809;
  localparam logic [7:0] ESMC_SUBTYPE = 8'h0a;
  localparam logic [7:0] ESMC_VERSION = 8'h10;
  localparam logic [7:0] QL_TLV_TYPE = 8'h01;
  localparam logic [15:0] QL_TLV_LEN = 16'h0004;
  localparam logic [3:0] QL_DNU = 4'hf;
  localparam logic [5:0] POS_SA = 6'd6;
  localparam logic [5:0] POS_ETYPE = 6'd12;
  localparam logic [5:0] POS_SUBTYPE = 6'd14;
  localparam logic [5:0] POS_ORG = 6'd15;
  localparam logic [5:0] POS_ORG_SUB = 6'd18;
  localparam logic [5:0] POS_VERSION = 6'd20;
  localparam logic [5:0] POS_TLV = 6'd24;
  localparam logic [5:0] POS_QL = 6'd27;
  localparam logic [5:0] FRAME_LAST = 6'd59;

endpackage

// ==== rtl/level_sync.sv ====
// Two-stage synchroniser for levels and toggle bits entering a clock domain.
// Assumes each bit is independent; multi-bit words must not be passed here.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int W = 1
) (
  // Destination clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Level from the other domain, and its synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // The first stage is read only by the second stage.
  logic [W-1:0] meta;

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  // Both stages clear to zero so toggle crossings start out balanced.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/esmc_frame_rom.sv ====
// Byte lookup for the transmitted ESMC frame, indexed by byte position.
// Assumes the caller holds the quality code stable for the whole frame.
`timescale 1ns/1ps
`default_nettype none

module esmc_frame_rom #(
  parameter logic [47:0] SRC_ADDR = 48'h020000000001,
  parameter logic [23:0] ORG_ID = 24'h000000
) (
  // Byte position and quality code to place in the QL TLV.
  input wire logic [5:0] idx,
  input wire logic [3:0] ql,
  // Frame byte and end-of-frame marker.
  output logic [7:0] data,
  output logic last
);

  logic [5:0] k;

  // ==========================================================================
  // Byte table
  // ==========================================================================
  // Positions not named below are padding and read as zero.
  always_comb begin
    k = 6'd0;
    data = 8'h00;
    if (idx < esmc_pkg::POS_SA) begin
      k = esmc_pkg::POS_SA - 6'd1 - idx;
      data = esmc_pkg::SLOW_PROTO_DA[{k[2:0], 3'b000} +: 8];
    end else if (idx < esmc_pkg::POS_ETYPE) begin
      k = esmc_pkg::POS_ETYPE - 6'd1 - idx;
      data = SRC_ADDR[{k[2:0], 3'b000} +: 8];
    end else if (idx == esmc_pkg::POS_ETYPE) begin
      data = esmc_pkg::SLOW_PROTO_ETYPE[15:8];
    end else if (idx == esmc_pkg::POS_ETYPE + 6'd1) begin
      data = esmc_pkg::SLOW_PROTO_ETYPE[7:0];
    end else if (idx == esmc_pkg::POS_SUBTYPE) begin
      data = esmc_pkg::ESMC_SUBTYPE;
    end else if (idx >= esmc_pkg::POS_ORG && idx < esmc_pkg::POS_ORG_SUB) begin
      k = esmc_pkg::POS_ORG_SUB - 6'd1 - idx;
      data = ORG_ID[{k[1:0], 3'b000} +: 8];
    end else if (idx == esmc_pkg::POS_ORG_SUB + 6'd1) begin
      data = 8'h01;
    end else if (idx == esmc_pkg::POS_VERSION) begin
      data = esmc_pkg::ESMC_VERSION;
    end else if (idx == esmc_pkg::POS_TLV) begin
      data = esmc_pkg::QL_TLV_TYPE;
    end else if (idx == esmc_pkg::POS_TLV + 6'd1) begin
      data = esmc_pkg::QL_TLV_LEN[15:8];
    end else if (idx == esmc_pkg::POS_TLV + 6'd2) begin
      data = esmc_pkg::QL_TLV_LEN[7:0];
    end else if (idx == esmc_pkg::POS_QL) begin
      data = {4'h0, ql};
    end
    last = (idx == esmc_pkg::FRAME_LAST);
  end

endmodule
`default_nettype wire

// ==== dv/esmc_link_peer.sv ====
// Model of the customer equipment at the far end of the link.
// Assumes the bench makes link_clk and calls send_frame.
`timescale 1ns/1ps
`default_nettype none

// ====================
// Link peer
// ====================
module esmc_link_peer (
  // Link clock and reset.
  input wire logic link_clk,
  input wire logic rst_n,
  // Stream from the port.
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // Stream towards the port.
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  // Bench control.
  input wire logic slow
);
  logic [7:0] cap [0:59];
  int cap_idx = 0;
  int frames = 0;
  logic ph = 1'b0;
  realtime t_start = 0;

  // Idle lines start low; data is inverted after each frame.
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end

  // Slow mode takes every other byte, so the port must hold its byte.
  always @(posedge link_clk) begin
    ph <= ~ph;
    tx_ready <= !slow || ph;
  end

  // Capture of accepted bytes; the count moves on the last byte.
  always @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_idx <= 0;
    end else if (tx_valid && tx_ready && cap_idx < 60) begin
      cap[cap_idx] <= tx_data;
      t_start <= (cap_idx == 0) ? $realtime : t_start;
      cap_idx <= tx_last ? 0 : cap_idx + 1;
      frames <= frames + (tx_last ? 1 : 0);
    end
  end

  // Byte i of a frame carrying quality code ql.
  function automatic logic [7:0] frame_byte(input int i, input logic [3:0] ql);
    case (i)
      0, 1, 2, 3, 4, 5: return esmc_pkg::SLOW_PROTO_DA[8 * (5 - i) +: 8];
      12: return esmc_pkg::SLOW_PROTO_ETYPE[15:8];
      13: return esmc_pkg::SLOW_PROTO_ETYPE[7:0];
      14: return esmc_pkg::ESMC_SUBTYPE;
      19: return 8'h01;
      20: return esmc_pkg::ESMC_VERSION;
      24: return esmc_pkg::QL_TLV_TYPE;
      26: return 8'h04;
      27: return {4'h0, ql};
      default: return 8'h00;
    endcase
  endfunction

  // Sends one frame; the peer normally reports do-not-use.
  task automatic send_frame(input logic [3:0] ql);
    for (int i = 0; i < 60; i++) begin
      @(posedge link_clk);
      rx_valid <= 1'b1;
      rx_data <= frame_byte(i, ql);
      rx_last <= (i == 59);
    end
    @(posedge link_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule
`default_nettype wire

// ==== dv/sync_ethernet_esmc_ql_control_props.sv ====
// Checker for the port controller, bound to the top module's ports.
// Assumes both clocks share one asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

// ====================
// Checker
// ====================
module esmc_ctl_chk (
  // Clocks and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic link_clk,
  // Watched ports.
  input wire logic cfg_sync_mode,
  input wire logic pair_lock,
  input wire logic tx_clk_from_eec,
  input wire logic clock_source_selectable,
  input wire logic esmc_active,
  input wire logic ql_active,
  input wire logic peer_ql_update,
  input wire logic esmc_rx_dropped,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready
);
  logic [7:0] off_cnt;

  // Cycles since ESMC went off; a launched frame may start just after.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      off_cnt <= 8'h00;
    end else if (esmc_active) begin
      off_cnt <= 8'h00;
    end else if (off_cnt != 8'hff) begin
      off_cnt <= off_cnt + 8'h01;
    end
  end

  // Named steps; sync_rise is shared by two properties, both_on serves one.
  sequence sync_rise;
    $rose(cfg_sync_mode) && !pair_lock;
  endsequence
  sequence both_on;
    (esmc_active && tx_clk_from_eec) [*2];
  endsequence

  a_sync_eec: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sync_rise |-> ##2 tx_clk_from_eec) else $error("eec select late");
  a_esmc_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sync_rise |-> ##2 esmc_active) else $error("esmc not on by default");
  a_sync_off_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!cfg_sync_mode && !pair_lock) [*3] |-> !tx_clk_from_eec && !esmc_active && !ql_active)
    else $error("sync off not idle");
  a_not_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
    both_on |-> !clock_source_selectable) else $error("offered as source");
  a_ql_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ql_active [*8] |-> !peer_ql_update) else $error("peer code taken with QL off");
  a_drop_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    esmc_active [*5] |-> !esmc_rx_dropped) else $error("drop with ESMC on");
  a_off_no_tx: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(tx_valid) |-> off_cnt < 8'h64) else $error("frame with ESMC off");
  a_tx_hold: assert property (@(posedge link_clk) disable iff (!rst_n)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("byte not held");
  a_frame_da: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(tx_valid) |-> tx_data == 8'h01) else $error("bad first byte");
endmodule

bind sync_ethernet_esmc_ql_control esmc_ctl_chk u_esmc_ctl_chk (.clk_sys, .rst_n, .link_clk,
  .cfg_sync_mode, .pair_lock, .tx_clk_from_eec, .clock_source_selectable, .esmc_active,
  .ql_active, .peer_ql_update, .esmc_rx_dropped, .tx_valid, .tx_data, .tx_last, .tx_ready);
`default_nettype wire

// ==== dv/sync_ethernet_esmc_ql_control_test.sv ====
// Self-checking bench for the port controller with a link peer model.
// Assumes the package, design, peer and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

// ====================
// Bench
// ====================
module sync_ethernet_esmc_ql_control_test;
  localparam int unsigned SEC = 2000;
  localparam logic [47:0] SRC = 48'h02a1b2c3d4e5;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_sync_mode = 1'b0;
  logic pair_lock = 1'b0;
  logic pair_sync_mode = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic ql_fault = 1'b0;
  logic [3:0] local_ql = 4'h0;
  logic other_slow_req = 1'b0;
  logic slow = 1'b0;
  logic other_slow_grant, tx_clk_from_eec, clock_source_selectable, esmc_active, ql_active;
  logic peer_ql_update, esmc_rx_dropped, tx_valid, tx_last, tx_ready, rx_valid, rx_last;
  logic [3:0] peer_ql;
  logic [7:0] tx_data, rx_data;
  logic got;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  int grants = 0;
  int drops = 0;
  realtime t_last = 0;
  realtime gap = 0;

  // Two clocks of unrelated phase.
  always #5 clk_sys = ~clk_sys;
  initial begin
    #3.3;
    forever begin
      link_clk = ~link_clk;
      #62.5;
    end
  end

  // A short second keeps the run brief; commands are bits of cmd.
  sync_ethernet_esmc_ql_control #(.ONE_SEC(SEC), .SRC_ADDR(SRC)) u_sync_ethernet_esmc_ql_control (
    .clk_sys, .rst_n, .link_clk, .cfg_sync_mode, .pair_lock, .pair_sync_mode,
    .cmd_esmc_enable(cmd[0]), .cmd_esmc_disable(cmd[1]), .cmd_ql_enable(cmd[2]),
    .cmd_ql_disable(cmd[3]), .ql_fault, .local_ql, .other_slow_req, .other_slow_grant,
    .tx_clk_from_eec, .clock_source_selectable, .esmc_active, .ql_active, .peer_ql,
    .peer_ql_update, .esmc_rx_dropped, .tx_valid, .tx_data, .tx_last, .tx_ready,
    .rx_valid, .rx_data, .rx_last);
  esmc_link_peer u_esmc_link_peer (.link_clk, .rst_n, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .rx_valid, .rx_data, .rx_last, .slow);

  // Tallies of grants and drops; a ceiling cuts a hang short.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    grants <= grants + (other_slow_grant === 1'b1 ? 1 : 0);
    drops <= drops + (esmc_rx_dropped === 1'b1 ? 1 : 0);
    if (cycles == 80000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic pulse(input logic [3:0] c);
    cmd <= c;
    @(posedge clk_sys);
    cmd <= 4'h0;
    cyc(4);
  endtask

  // Waits for a whole frame and notes the spacing of starts.
  task automatic wait_frame(input int lim);
    int n;
    n = u_esmc_link_peer.frames;
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clk_sys);
      got = (u_esmc_link_peer.frames != n);
    end
    gap = u_esmc_link_peer.t_start - t_last;
    t_last = u_esmc_link_peer.t_start;
  endtask

  task automatic check_frame(input logic [3:0] ql);
    logic [7:0] e;
    for (int i = 0; i < 60; i++) begin
      e = (i >= 6 && i < 12) ? SRC[8 * (11 - i) +: 8] : u_esmc_link_peer.frame_byte(i, ql);
      check(u_esmc_link_peer.cap[i], e);
    end
  endtask

  // Out of reset everything is off and commands are refused.
  task automatic t_reset();
    pulse(4'h1);
    check(esmc_active, 1'b0);
    check(tx_clk_from_eec, 1'b0);
    check(clock_source_selectable, 1'b1);
    check(peer_ql, 4'hf);
    wait_frame(2 * SEC);
    check(got, 1'b0);
  endtask

  // Sync on, then one frame a second carrying every quality code.
  task automatic t_sync_on();
    local_ql <= 4'h2;
    cfg_sync_mode <= 1'b1;
    cyc(4);
    check(tx_clk_from_eec, 1'b1);
    check(esmc_active, 1'b1);
    check(ql_active, 1'b1);
    check(clock_source_selectable, 1'b0);
    wait_frame(2 * SEC);
    check(got, 1'b1);
    for (int q = 0; q < 16; q++) begin
      local_ql <= q[3:0];
      slow <= q[0];
      wait_frame(2 * SEC);
      check(got, 1'b1);
      check(gap > SEC * 10 - 300 && gap < SEC * 10 + 300, 1'b1);
      check_frame(q[3:0]);
      check(u_esmc_link_peer.cap[27], {4'h0, q[3:0]});
    end
  endtask

  // Quality handling off and on, by command and by fault.
  task automatic t_ql();
    local_ql <= 4'h3;
    pulse(4'h8);
    check(ql_active, 1'b0);
    wait_frame(2 * SEC);
    check(u_esmc_link_peer.cap[27], 8'h0f);
    u_esmc_link_peer.send_frame(4'h2);
    cyc(20);
    check(peer_ql, 4'hf);
    pulse(4'h4);
    check(ql_active, 1'b1);
    u_esmc_link_peer.send_frame(4'h2);
    cyc(20);
    check(peer_ql, 4'h2);
    ql_fault <= 1'b1;
    wait_frame(2 * SEC);
    wait_frame(2 * SEC);
    check(u_esmc_link_peer.cap[27], 8'h0f);
    ql_fault <= 1'b0;
  endtask

  // ESMC off keeps the slave clock, drops frames and sends none.
  task automatic t_esmc_off();
    pulse(4'h2);
    check(esmc_active, 1'b0);
    check(tx_clk_from_eec, 1'b1);
    check(clock_source_selectable, 1'b1);
    u_esmc_link_peer.send_frame(4'hf);
    cyc(20);
    check(drops, 1);
    check(peer_ql, 4'h2);
    wait_frame(2 * SEC);
    check(got, 1'b0);
    pulse(4'h1);
    check(esmc_active, 1'b1);
    wait_frame(2 * SEC);
    check(got, 1'b1);
  endtask

  // The shared pair setting overrides the link's own.
  task automatic t_pair();
    pair_lock <= 1'b1;
    cyc(5);
    check(tx_clk_from_eec, 1'b0);
    check(esmc_active, 1'b0);
    pair_sync_mode <= 1'b1;
    cyc(5);
    check(tx_clk_from_eec, 1'b1);
    check(esmc_active, 1'b1);
    pair_lock <= 1'b0;
    cyc(3);
  endtask

  // Other slow-protocol users asking nonstop stay within the budget.
  task automatic t_budget();
    int g0;
    g0 = grants;
    other_slow_req <= 1'b1;
    cyc(2 * SEC);
    other_slow_req <= 1'b0;
    cyc(2);
    check(grants - g0 >= 9 && grants - g0 <= 29, 1'b1);
  endtask

  // Main sequence; reset also spans two link clock edges.
  initial begin
    cyc(14);
    rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_sync_on();
    t_ql();
    t_esmc_off();
    t_pair();
    t_budget();
    print_verdict();
  end
endmodule
`default_nettype wire
